// *** src/hold_timer.v ***
// saturating hold timer: done once run has stood for limit cycles
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
  parameter integer LIMIT = 2500,
  parameter integer W     = 16
) (
  // clock and reset
  input  wire         clk,
  input  wire         nrst,
  // control
  input  wire         run,
  output reg          done
);
  reg [W-1:0] count;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= {W{1'b0}};
      done  <= 1'b0;
    end else if (!run) begin
      count <= {W{1'b0}};
      done  <= 1'b0;
    end else if (count >= LIMIT[W-1:0] - 1'b1) begin
      done <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // hold_timer
`default_nettype wire

// *** src/node_mode_ctrl.v ***
// node mode controller of a bus transceiver
// Function
// - select rising edge sets wake; Normal clears
// - wake set clears all undervoltage flags
// - early go-to-sleep exit enters the pin-selected mode
// - long go-to-sleep, wake clear: enter Sleep
// - wake from Sleep passes through Standby
// - io/battery undervoltage forces Sleep; core undervoltage forces Standby from Normal or Receive-only
// - any undervoltage detection clears wake
// - recovery from Sleep enters Standby, battery recovery sets wake
// - Normal routes receiver to receive data
// - Normal drives both inhibits high
// - transmitter gated by guardian, gate, faults
// - enabled transmitter drives plus/minus from data
// - pins select mode absent undervoltage, except in Sleep
// - Standby wake drives inhibit two, receive low
// - Receive-only keeps transmitter off, inhibits high
`timescale 1ns/1ps
`default_nettype none
`include "node_mode_regs.vh"
module node_mode_ctrl #(
  parameter integer GOTOSLEEP_CYCLES = `GOTOSLEEP_CYCLES,
  parameter integer SELECT_CYCLES    = `SELECT_CYCLES
) (
  // clock and reset
  input  wire                clk,
  input  wire                nrst,
  // host control pins
  input  wire                low_power_select_n,
  input  wire                mode_select,
  // supply monitors, high while undervoltage
  input  wire                io_supply_low,
  input  wire                battery_low,
  input  wire                core_supply_low,
  input  wire                power_on_event,
  // transmitter inputs
  input  wire                bus_guardian_gate,
  input  wire                transmit_gate_n,
  input  wire                transmit_data,
  input  wire                tx_timeout,
  input  wire                overtemp,
  // normal receiver
  input  wire                rx_data_in,
  input  wire                rx_activity_in,
  // mode and flags
  output reg  [`MODE_W-1:0]  mode,
  output reg                 wake_flag,
  output reg                 power_on_flag,
  output reg                 io_supply_low_flag,
  output reg                 battery_low_flag,
  output reg                 core_supply_low_flag,
  output reg                 select_too_early,
  // inhibits, enable high while driving
  output reg                 inhibit_out_one,
  output reg                 inhibit_out_one_oe,
  output reg                 inhibit_out_two,
  output reg                 inhibit_out_two_oe,
  // receive outputs
  output reg                 receive_activity_n,
  output reg                 receive_data,
  // bus drivers
  output reg                 bus_plus,
  output reg                 bus_minus,
  output reg                 bus_drive_en
);
  localparam [4:0] S_NORMAL  = 5'h01;
  localparam [4:0] S_RXONLY  = 5'h02;
  localparam [4:0] S_GOSLEEP = 5'h04;
  localparam [4:0] S_STANDBY = 5'h08;
  localparam [4:0] S_SLEEP   = 5'h10;

  reg  [4:0] state;
  reg  [4:0] next_state;
  reg        next_wake;
  reg        next_uv_io;
  reg        next_uv_bat;
  reg        next_uv_core;
  reg        sel_d;
  reg        ms_d;
  reg        io_d;
  reg        bat_d;
  reg        core_d;
  reg        ms_low_win;
  wire       sleep_hold_done;
  wire       select_ok;
  wire       sel_rise = low_power_select_n & ~sel_d;
  wire       ms_fall  = ~mode_select & ms_d;

  function [4:0] pin_mode;
    input s;
    input m;
    begin
      case ({s, m})
        2'b11:   pin_mode = S_NORMAL;
        2'b10:   pin_mode = S_RXONLY;
        2'b01:   pin_mode = S_GOSLEEP;
        default: pin_mode = S_STANDBY;
      endcase
    end
  endfunction

  function [`MODE_W-1:0] mode_code;
    input [4:0] s;
    begin
      case (s)
        S_NORMAL:  mode_code = `MODE_NORMAL;
        S_RXONLY:  mode_code = `MODE_RXONLY;
        S_GOSLEEP: mode_code = `MODE_GOSLEEP;
        S_STANDBY: mode_code = `MODE_STANDBY;
        default:   mode_code = `MODE_SLEEP;
      endcase
    end
  endfunction

  // go-to-sleep hold time
  hold_timer #(.LIMIT(GOTOSLEEP_CYCLES), .W(20)) u_gotosleep (
    .clk  (clk),
    .nrst (nrst),
    .run  (state == S_GOSLEEP && !wake_flag),
    .done (sleep_hold_done)
  );

  // select detect window after mode-select falls
  hold_timer #(.LIMIT(SELECT_CYCLES), .W(20)) u_select (
    .clk  (clk),
    .nrst (nrst),
    .run  (ms_low_win),
    .done (select_ok)
  );

  always @* begin
    next_uv_io   = io_supply_low_flag;
    next_uv_bat  = battery_low_flag;
    next_uv_core = core_supply_low_flag;
    next_wake    = wake_flag;
    next_state   = state;
    if (io_supply_low & ~io_d) next_uv_io = 1'b1;
    if (battery_low & ~bat_d) next_uv_bat = 1'b1;
    if (core_supply_low & ~core_d) next_uv_core = 1'b1;
    // supply recovery; battery recovery from Sleep counts as wake
    if (!io_supply_low && io_d) next_uv_io = 1'b0;
    if (!core_supply_low && core_d) next_uv_core = 1'b0;
    if (!battery_low && bat_d) begin
      next_uv_bat = 1'b0;
      if (state == S_SLEEP) next_wake = 1'b1;
    end
    // select wake only while the io supply is present
    if (sel_rise && !io_supply_low) next_wake = 1'b1;
    if (next_wake && !wake_flag) begin
      next_uv_io   = 1'b0;
      next_uv_bat  = 1'b0;
      next_uv_core = 1'b0;
    end
    // detection wins over a same-cycle wake
    if ((io_supply_low & ~io_d) | (battery_low & ~bat_d) |
        (core_supply_low & ~core_d))
      next_wake = 1'b0;
    case (state)
      S_SLEEP: begin
        if (!next_uv_io && !next_uv_bat && next_wake)
          next_state = S_STANDBY;
        else if (!next_uv_io && !next_uv_bat && low_power_select_n)
          next_state = S_STANDBY;
      end
      S_GOSLEEP: begin
        if (sleep_hold_done && !wake_flag) next_state = S_SLEEP;
        else next_state = pin_mode(low_power_select_n, mode_select);
      end
      default: next_state = pin_mode(low_power_select_n, mode_select);
    endcase
    if (next_uv_io || next_uv_bat) begin
      next_state = S_SLEEP;
    end else if (next_uv_core &&
                 (next_state == S_NORMAL || next_state == S_RXONLY)) begin
      next_state = S_STANDBY;
    end
    if (next_state == S_NORMAL) next_wake = 1'b0;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state                <= S_STANDBY;
      mode                 <= `MODE_STANDBY;
      wake_flag            <= 1'b0;
      power_on_flag        <= 1'b1;
      io_supply_low_flag   <= 1'b0;
      battery_low_flag     <= 1'b0;
      core_supply_low_flag <= 1'b0;
      sel_d                <= 1'b0;
      ms_d                 <= 1'b0;
      io_d                 <= 1'b0;
      bat_d                <= 1'b0;
      core_d               <= 1'b0;
      ms_low_win           <= 1'b0;
      select_too_early     <= 1'b0;
    end else begin
      state                <= next_state;
      mode                 <= mode_code(next_state);
      wake_flag            <= next_wake;
      io_supply_low_flag   <= next_uv_io;
      battery_low_flag     <= next_uv_bat;
      core_supply_low_flag <= next_uv_core;
      sel_d                <= low_power_select_n;
      ms_d                 <= mode_select;
      io_d                 <= io_supply_low;
      bat_d                <= battery_low;
      core_d               <= core_supply_low;
      // power-on flag cleared on leaving Normal, set by a power event
      if (power_on_event) power_on_flag <= 1'b1;
      else if (state == S_NORMAL && next_state != S_NORMAL)
        power_on_flag <= 1'b0;
      // check host timing when leaving Normal toward Standby
      if (state == S_NORMAL && ms_fall && low_power_select_n)
        ms_low_win <= 1'b1;
      else if (mode_select || !low_power_select_n)
        ms_low_win <= 1'b0;
      // only both pins low counts; select low with mode high is go-to-sleep
      if (ms_low_win && !low_power_select_n && !mode_select && !select_ok)
        select_too_early <= 1'b1;
      else if (state == S_NORMAL && ms_fall)
        select_too_early <= 1'b0;
    end
  end

  // pin outputs, registered from the next state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inhibit_out_one    <= 1'b1;
      inhibit_out_one_oe <= 1'b1;
      inhibit_out_two    <= 1'b0;
      inhibit_out_two_oe <= 1'b0;
      receive_activity_n <= 1'b1;
      receive_data       <= 1'b1;
      bus_plus           <= 1'b0;
      bus_minus          <= 1'b0;
      bus_drive_en       <= 1'b0;
    end else begin
      inhibit_out_one    <= 1'b1;
      inhibit_out_one_oe <= (next_state != S_SLEEP);
      inhibit_out_two    <= 1'b1;
      inhibit_out_two_oe <= (next_state == S_NORMAL) ||
                            (next_state == S_RXONLY) || next_wake;
      bus_plus     <= 1'b0;
      bus_minus    <= 1'b0;
      bus_drive_en <= 1'b0;
      if (next_state == S_NORMAL || next_state == S_RXONLY) begin
        receive_activity_n <= ~rx_activity_in;
        receive_data       <= rx_data_in;
      end else begin
        receive_activity_n <= ~next_wake;
        receive_data       <= ~next_wake;
      end
      // Receive-only never enables the driver
      if (next_state == S_NORMAL && bus_guardian_gate && !transmit_gate_n &&
          !tx_timeout && !overtemp) begin
        bus_drive_en <= 1'b1;
        bus_plus     <= transmit_data;
        bus_minus    <= ~transmit_data;
      end
    end
  end
endmodule // node_mode_ctrl
`default_nettype wire

// *** src/node_mode_regs.vh ***
// constants for the node mode controller
`ifndef NODE_MODE_REGS_VH
`define NODE_MODE_REGS_VH
`define CLK_MHZ           125
`define GOTOSLEEP_HOLD_US 20
`define SELECT_DETECT_US  20
`define GOTOSLEEP_CYCLES  (`GOTOSLEEP_HOLD_US * `CLK_MHZ)
`define SELECT_CYCLES     (`SELECT_DETECT_US * `CLK_MHZ)
`define MODE_W            3
`define MODE_NORMAL       3'h0
`define MODE_RXONLY       3'h1
`define MODE_GOSLEEP      3'h2
`define MODE_STANDBY      3'h3
`define MODE_SLEEP        3'h4
`endif

// *** testbench/bus_transceiver_node_mode_control_tb.sv ***
// self-checking bench for the node mode controller
`timescale 1ns/1ps
`default_nettype none
`include "node_mode_regs.vh"
module bus_transceiver_node_mode_control_tb;
  localparam integer HOLD = 10;
  localparam integer SEL  = 10;
  logic clk = 1'b0, nrst = 1'b0, io_supply_low = 1'b0, battery_low = 1'b0;
  logic core_supply_low = 1'b0, power_on_event = 1'b0, bus_guardian_gate = 1'b0;
  logic transmit_gate_n = 1'b1, transmit_data = 1'b0, tx_timeout = 1'b0;
  logic overtemp = 1'b0, rx_data_in = 1'b0, rx_activity_in = 1'b1;
  wire low_power_select_n, mode_select;
  wire [`MODE_W-1:0] mode;
  wire wake_flag, power_on_flag, io_supply_low_flag, battery_low_flag;
  wire core_supply_low_flag, select_too_early, inhibit_out_one;
  wire inhibit_out_one_oe, inhibit_out_two, inhibit_out_two_oe;
  wire receive_activity_n, receive_data, bus_plus, bus_minus, bus_drive_en;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [5:0] v;
  always #4 clk = ~clk;
  node_mode_ctrl #(.GOTOSLEEP_CYCLES(HOLD), .SELECT_CYCLES(SEL))
    i_node_mode_ctrl (.*);
  host_pins_model #(.SELECT_CYCLES(SEL)) i_host_pins_model (.*);
  function automatic logic [2:0] pin_mode(input logic s, input logic m);
    return s ? (m ? `MODE_NORMAL : `MODE_RXONLY)
             : (m ? `MODE_GOSLEEP : `MODE_STANDBY);
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [2:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(70));
    step(2);
    nrst = 1'b1;
    // go-to-sleep held one cycle only, then standby
    for (int i = 3; i >= 0; i--) begin
      i_host_pins_model.go(i[1], i[0]);
      step(1);
      chk("mode", pin_mode(i[1], i[0]), mode);
    end
    // rx-only to go-to-sleep is legal host timing
    chk("early", 3'h0, select_too_early);
    i_host_pins_model.go(1'b1, 1'b1);
    step(1);
    chk("inhibits", 3'h1, inhibit_out_one & inhibit_out_two);
    chk("inhibit_out_one oe", 3'h1, inhibit_out_one_oe);
    for (int i = 0; i < 164; i++) begin
      v = (i < 64) ? 6'(i) : 6'($urandom);
      {bus_guardian_gate, transmit_gate_n, transmit_data} = v[5:3];
      {tx_timeout, overtemp, rx_data_in} = v[2:0];
      step(1);
      chk("drive", v[5] & !v[4] & !v[2] & !v[1], bus_drive_en);
      if (bus_drive_en === 1'b1) begin
        chk("plus", transmit_data, bus_plus);
        chk("minus", !transmit_data, bus_minus);
      end
      chk("rx", rx_data_in, receive_data);
    end
    i_host_pins_model.go(1'b1, 1'b0);
    {bus_guardian_gate, transmit_gate_n, tx_timeout, overtemp} = 4'h8;
    step(2);
    chk("drive", 3'h0, bus_drive_en);
    i_host_pins_model.go(1'b1, 1'b1);
    step(1);
    i_host_pins_model.go(1'b0, 1'b1);
    step(HOLD + 3);
    chk("mode", `MODE_SLEEP, mode);
    i_host_pins_model.go(1'b1, 1'b1);
    step(1);
    chk("mode", `MODE_STANDBY, mode);
    chk("wake", 3'h1, wake_flag);
    step(1);
    chk("mode", `MODE_NORMAL, mode);
    chk("wake", 3'h0, wake_flag);
    core_supply_low = 1'b1;
    step(1);
    chk("mode", `MODE_STANDBY, mode);
    chk("core flag", 3'h1, core_supply_low_flag);
    i_host_pins_model.go(1'b0, 1'b0);
    step(1);
    i_host_pins_model.go(1'b1, 1'b0);
    step(1);
    chk("wake", 3'h1, wake_flag);
    chk("core flag", 3'h0, core_supply_low_flag);
    io_supply_low = 1'b1;
    step(1);
    chk("mode", `MODE_SLEEP, mode);
    chk("wake", 3'h0, wake_flag);
    chk("io flag", 3'h1, io_supply_low_flag);
    io_supply_low = 1'b0;
    step(1);
    chk("mode", `MODE_STANDBY, mode);
    step(1);
    chk("mode", `MODE_RXONLY, mode);
    battery_low = 1'b1;
    step(1);
    chk("mode", `MODE_SLEEP, mode);
    chk("bat flag", 3'h1, battery_low_flag);
    battery_low = 1'b0;
    step(1);
    chk("mode", `MODE_STANDBY, mode);
    chk("wake", 3'h1, wake_flag);
    chk("bat flag", 3'h0, battery_low_flag);
    chk("early", 3'h0, select_too_early);
    results;
  end
  initial begin
    #100000;
    error_cnt++;
    results;
  end
endmodule // bus_transceiver_node_mode_control_tb
`default_nettype wire

// *** testbench/host_pins_model.sv ***
// host side model driving the two mode control pins
`timescale 1ns/1ps
`default_nettype none
module host_pins_model #(
  parameter integer SELECT_CYCLES = 10
) (
  input  wire logic clk,
  output var  logic low_power_select_n,
  output var  logic mode_select
);
  initial begin
    low_power_select_n = 1'b0;
    mode_select        = 1'b0;
  end
  // select waits past the detect time so the device does not set select_too_early
  task automatic go(input logic s, input logic m);
    if (!s && !m && low_power_select_n && mode_select) begin
      mode_select = 1'b0;
      repeat (SELECT_CYCLES + 2) @(posedge clk);
      #1;
    end
    low_power_select_n = s;
    mode_select        = m;
  endtask
endmodule // host_pins_model
`default_nettype wire

// *** testbench/node_mode_ctrl_assertions.sv ***
// concurrent checks on the node mode controller ports
`timescale 1ns/1ps
`default_nettype none
`include "node_mode_regs.vh"
module node_mode_ctrl_checker (
  // clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // supply monitors
  input wire logic               io_supply_low,
  input wire logic               battery_low,
  input wire logic               core_supply_low,
  // transmitter and receiver inputs
  input wire logic               bus_guardian_gate,
  input wire logic               transmit_gate_n,
  input wire logic               transmit_data,
  input wire logic               tx_timeout,
  input wire logic               overtemp,
  input wire logic               rx_data_in,
  // mode and flags
  input wire logic [`MODE_W-1:0] mode,
  input wire logic               wake_flag,
  input wire logic               io_supply_low_flag,
  input wire logic               battery_low_flag,
  input wire logic               core_supply_low_flag,
  // pins
  input wire logic               inhibit_out_one,
  input wire logic               inhibit_out_two,
  input wire logic               inhibit_out_two_oe,
  input wire logic               receive_activity_n,
  input wire logic               receive_data,
  input wire logic               bus_plus,
  input wire logic               bus_minus,
  input wire logic               bus_drive_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire norm = mode == `MODE_NORMAL;
  property p_inh_normal;
    norm |-> inhibit_out_one && inhibit_out_two && inhibit_out_two_oe;
  endproperty
  a_inh_normal: assert property (p_inh_normal) else $error("inhibit low");
  property p_rx_route;
    norm && $past(norm) |-> receive_data == $past(rx_data_in);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx not routed");
  property p_tx_gate;
    bus_drive_en |->
      $past(bus_guardian_gate && !transmit_gate_n && !tx_timeout && !overtemp);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx not gated");
  property p_tx_data;
    bus_drive_en |-> bus_plus == $past(transmit_data) && bus_minus != bus_plus;
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("bus level wrong");
  property p_rxonly;
    mode == `MODE_RXONLY && $past(mode) == `MODE_RXONLY |-> !bus_drive_en;
  endproperty
  a_rxonly: assert property (p_rxonly) else $error("tx in rx-only");
  property p_wake_uv;
    $rose(wake_flag) |->
      !(io_supply_low_flag || battery_low_flag || core_supply_low_flag);
  endproperty
  a_wake_uv: assert property (p_wake_uv) else $error("uv flag kept");
  property p_standby_wake;
    mode == `MODE_STANDBY && wake_flag |-> inhibit_out_two &&
      inhibit_out_two_oe && !receive_activity_n && !receive_data;
  endproperty
  a_standby_wake: assert property (p_standby_wake) else $error("wake pins");
  property p_uv_sleep;
    $rose(io_supply_low) || $rose(battery_low) |=> mode == `MODE_SLEEP;
  endproperty
  a_uv_sleep: assert property (p_uv_sleep) else $error("no forced sleep");
  property p_uv_wake;
    $rose(io_supply_low) || $rose(battery_low) || $rose(core_supply_low)
      |=> !wake_flag;
  endproperty
  a_uv_wake: assert property (p_uv_wake) else $error("wake kept on uv");
  c_sleep: cover property (mode == `MODE_SLEEP);
  c_drive: cover property (bus_drive_en);
  c_wake: cover property (mode == `MODE_STANDBY && wake_flag);
endmodule // node_mode_ctrl_checker
bind node_mode_ctrl node_mode_ctrl_checker i_node_mode_ctrl_checker (.*);
`default_nettype wire
